/* File: hdl/pin_func_pkg.sv */
// Constants and types for the general-purpose pin function select block
package pin_func_pkg;

   // Register byte indices; byte address is four times the index
   localparam logic [3:0] idx_pin0_setting  = 4'h0;
   localparam logic [3:0] idx_pin1_setting  = 4'h1;
   localparam logic [3:0] idx_pin2_setting  = 4'h2;
   localparam logic [3:0] idx_pin3_setting  = 4'h3;
   localparam logic [3:0] idx_stored_base   = 4'h4;
   localparam logic [3:0] idx_usb_ctrl      = 4'h8;
   localparam logic [3:0] idx_usb_status    = 4'h9;
   localparam logic [3:0] idx_gpio_out      = 4'ha;
   localparam logic [3:0] idx_gpio_in       = 4'hb;

   // Setting byte fields
   localparam int unsigned out_level_bit = 4;
   localparam int unsigned direction_bit = 3;
   localparam int unsigned des_lsb       = 0;
   localparam logic [7:0]  setting_mask  = 8'h1f;

   // Reset values of the four setting bytes
   localparam logic [7:0] pin0_reset = 8'h12;
   localparam logic [7:0] pin1_reset = 8'h13;
   localparam logic [7:0] pin2_reset = 8'h11;
   localparam logic [7:0] pin3_reset = 8'h11;

   // Designation codes
   localparam logic [2:0] des_gpio  = 3'h0;
   localparam logic [2:0] des_dedic = 3'h1;
   localparam logic [2:0] des_alt0  = 3'h2;
   localparam logic [2:0] des_alt1  = 3'h3;
   localparam logic [2:0] des_alt2  = 3'h4;

   // usb_ctrl bits
   localparam int unsigned ctrl_resume_bit = 0;
   localparam int unsigned ctrl_config_bit = 1;

   // Timing
   localparam int unsigned clk_mhz          = 250;
   localparam int unsigned suspend_idle_us  = 3000;
   localparam int unsigned suspend_idle_cyc = suspend_idle_us * clk_mhz;
   localparam int unsigned led_pulse_us     = 5000;
   localparam int unsigned led_pulse_cyc    = led_pulse_us * clk_mhz;

   typedef enum logic [1:0] {st_boot, st_run} boot_state_t;

endpackage : pin_func_pkg

/* File: hdl/led_pulse_timer.sv */
// Stretches an activity strobe into an active-low LED pulse
module led_pulse_timer #(
   parameter int unsigned PULSE_CYC = pin_func_pkg::led_pulse_cyc
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Activity in, LED out
   input  wire logic activity,
   output logic      led_n
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic        led_n_q;
   logic        led_n_d;

   always_comb
   begin
      cnt_d   = cnt_q;
      if (activity)
         cnt_d = 32'(PULSE_CYC);
      else if (cnt_q != 32'h0)
         cnt_d = cnt_q - 32'h1;
      led_n_d = (cnt_d == 32'h0);
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cnt_q   <= 32'h0;
         led_n_q <= 1'b1;
      end
      else
      begin
         cnt_q   <= cnt_d;
         led_n_q <= led_n_d;
      end
   end

   assign led_n = led_n_q;

endmodule : led_pulse_timer

/* File: hdl/gp_pin_function_select.sv */
// Pin function multiplexer with USB suspend tracking and Avalon-MM registers
// How it works
// - Four setting bytes, indices zero to three
// - Bit 4 sets default driven level
// - Bit 3: one input, zero output
// - Pin zero: gpio, suspend, rx LED
// - Pin one: gpio, clock, adc, tx LED, edge
// - Pin two: gpio, configured, adc, dac
// - Pin three: gpio, two-wire LED, adc, dac
// - Enter suspend on detected suspend signalling
// - Leave suspend on resume or resets
// - Pull-up stays enabled while suspended
// - Working copy loads from stored copy at start
// - Suspend indicator low while suspended
// - Configured indicator follows configuration and suspend
// - Traffic LEDs pulse low on activity
//
// The implementer's own choice: the Avalon-MM register port.
module gp_pin_function_select #(
   parameter int unsigned IDLE_CYC  = pin_func_pkg::suspend_idle_cyc,
   parameter int unsigned PULSE_CYC = pin_func_pkg::led_pulse_cyc
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Avalon-MM slave
   input  wire logic [5:0] avs_address,
   input  wire logic       avs_read,
   input  wire logic       avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0] avs_byteenable,
   output logic [31:0]     avs_readdata,
   output logic            avs_waitrequest,
   // USB bus events
   input  wire logic       usb_traffic,
   input  wire logic       usb_resume,
   input  wire logic       usb_bus_reset,
   // Activity strobes and alternate sources
   input  wire logic       serial_rx_act,
   input  wire logic       serial_tx_act,
   input  wire logic       twowire_act,
   input  wire logic       clk_out_src,
   // Pins
   input  wire logic [3:0] pin_in,
   output logic [3:0]      pin_out,
   output logic [3:0]      pin_oe,
   // Analog and detector routing
   output logic [3:1]      analog_in_en,
   output logic [3:2]      analog_out_en,
   output logic            edge_detect_en,
   output logic            usb_pullup_en
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0]  work_q [4];
   logic [7:0]  work_d [4];
   logic [7:0]  store_q [4];
   logic [7:0]  store_d [4];
   logic [3:0]  gpio_q;
   logic [3:0]  gpio_d;
   logic        susp_q;
   logic        susp_d;
   logic        cfg_q;
   logic        cfg_d;
   logic [31:0] idle_q;
   logic [31:0] idle_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        ack_q;
   logic        ack_d;
   pin_func_pkg::boot_state_t boot_q;
   pin_func_pkg::boot_state_t boot_d;
   logic [3:0]  word_idx;
   logic [3:0]  led_n;

   // Reset values of a pin's setting byte
   function automatic logic [7:0] pin_reset(input int unsigned p);
      case (p)
         0:       pin_reset = pin_func_pkg::pin0_reset;
         1:       pin_reset = pin_func_pkg::pin1_reset;
         2:       pin_reset = pin_func_pkg::pin2_reset;
         default: pin_reset = pin_func_pkg::pin3_reset;
      endcase
   endfunction : pin_reset

   assign word_idx = avs_address[5:2];

   ////////////////////////////////////////////////////////////////////////////
   // Register access; one wait state so read data come from a flip-flop
   always_comb
   begin
      work_d  = work_q;
      store_d = store_q;
      gpio_d  = gpio_q;
      cfg_d   = cfg_q;
      rdata_d = rdata_q;
      // Bus reset drops configured; a software set in the same cycle wins
      if (usb_bus_reset)
         cfg_d = 1'b0;
      boot_d  = boot_q;
      ack_d   = 1'b0;
      if (boot_q == pin_func_pkg::st_boot)
      begin
         work_d = store_q;
         for (int p = 0; p < 4; p++)
            gpio_d[p] = store_q[p][pin_func_pkg::out_level_bit];
         boot_d = pin_func_pkg::st_run;
      end
      else if (avs_read || avs_write)
      begin
         ack_d = !ack_q;
         // Write lands at the edge that completes the transfer
         if (avs_write && ack_q && avs_byteenable[0])
         begin
            if (word_idx < pin_func_pkg::idx_stored_base)
            begin
               // Upper bits held at zero whatever is written
               work_d[word_idx[1:0]] = avs_writedata[7:0] & pin_func_pkg::setting_mask;
               gpio_d[word_idx[1:0]] = avs_writedata[pin_func_pkg::out_level_bit];
            end
            else if (word_idx < pin_func_pkg::idx_usb_ctrl)
               store_d[word_idx[1:0]] = avs_writedata[7:0] & pin_func_pkg::setting_mask;
            else if (word_idx == pin_func_pkg::idx_usb_ctrl)
            begin
               if (avs_writedata[pin_func_pkg::ctrl_config_bit])
                  cfg_d = 1'b1;
            end
            else if (word_idx == pin_func_pkg::idx_gpio_out)
               gpio_d = avs_writedata[3:0];
         end
         if (avs_read && !ack_q)
         begin
            if (word_idx < pin_func_pkg::idx_stored_base)
               rdata_d = {24'h0, work_q[word_idx[1:0]]};
            else if (word_idx < pin_func_pkg::idx_usb_ctrl)
               rdata_d = {24'h0, store_q[word_idx[1:0]]};
            else if (word_idx == pin_func_pkg::idx_usb_status)
               rdata_d = {30'h0, cfg_q, susp_q};
            else if (word_idx == pin_func_pkg::idx_gpio_out)
               rdata_d = {28'h0, gpio_q};
            else if (word_idx == pin_func_pkg::idx_gpio_in)
               rdata_d = {28'h0, pin_in};
            else
               rdata_d = 32'h0;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         for (int p = 0; p < 4; p++)
         begin
            work_q[p]  <= pin_reset(p);
            store_q[p] <= pin_reset(p);
         end
         gpio_q  <= 4'hf;
         cfg_q   <= 1'b0;
         rdata_q <= 32'h0;
         ack_q   <= 1'b0;
         boot_q  <= pin_func_pkg::st_boot;
      end
      else
      begin
         work_q  <= work_d;
         store_q <= store_d;
         gpio_q  <= gpio_d;
         cfg_q   <= cfg_d;
         rdata_q <= rdata_d;
         ack_q   <= ack_d;
         boot_q  <= boot_d;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign avs_readdata    = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Suspend tracking from bus idle time
   always_comb
   begin
      idle_d = idle_q;
      susp_d = susp_q;
      if (usb_traffic || usb_resume || usb_bus_reset)
      begin
         idle_d = 32'h0;
         susp_d = 1'b0;
      end
      else if (idle_q < 32'(IDLE_CYC))
         idle_d = idle_q + 32'h1;
      else
         susp_d = 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         idle_q <= 32'h0;
         susp_q <= 1'b0;
      end
      else
      begin
         idle_q <= idle_d;
         susp_q <= susp_d;
      end
   end

   // Pull-up never drops in suspend, else the host sees a detach
   assign usb_pullup_en = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Activity LEDs, one timer per traffic source
   led_pulse_timer #(.PULSE_CYC(PULSE_CYC)) u_led_rx (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .activity (serial_rx_act),
      .led_n    (led_n[0])
   );
   led_pulse_timer #(.PULSE_CYC(PULSE_CYC)) u_led_tx (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .activity (serial_tx_act),
      .led_n    (led_n[1])
   );
   led_pulse_timer #(.PULSE_CYC(PULSE_CYC)) u_led_tw (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .activity (twowire_act),
      .led_n    (led_n[3])
   );
   assign led_n[2] = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Pin multiplexer
   always_comb
   begin
      logic [2:0] des [4];
      for (int p = 0; p < 4; p++)
         des[p] = work_q[p][2:0];
      pin_out        = 4'h0;
      pin_oe         = 4'h0;
      analog_in_en   = 3'h0;
      analog_out_en  = 2'h0;
      edge_detect_en = 1'b0;
      for (int p = 0; p < 4; p++)
      begin
         // Direction bit ignored unless designated gpio
         if (des[p] == pin_func_pkg::des_gpio && !work_q[p][pin_func_pkg::direction_bit])
         begin
            pin_out[p] = gpio_q[p];
            pin_oe[p]  = 1'b1;
         end
      end
      case (des[0])
         pin_func_pkg::des_dedic:
         begin
            pin_out[0] = !susp_q;
            pin_oe[0]  = 1'b1;
         end
         pin_func_pkg::des_alt0:
         begin
            pin_out[0] = led_n[0];
            pin_oe[0]  = 1'b1;
         end
         default: ;
      endcase
      case (des[1])
         pin_func_pkg::des_dedic:
         begin
            pin_out[1] = clk_out_src;
            pin_oe[1]  = 1'b1;
         end
         pin_func_pkg::des_alt0: analog_in_en[1] = 1'b1;
         pin_func_pkg::des_alt1:
         begin
            pin_out[1] = led_n[1];
            pin_oe[1]  = 1'b1;
         end
         pin_func_pkg::des_alt2: edge_detect_en = 1'b1;
         default: ;
      endcase
      case (des[2])
         pin_func_pkg::des_dedic:
         begin
            pin_out[2] = cfg_q && !susp_q;
            pin_oe[2]  = 1'b1;
         end
         pin_func_pkg::des_alt0: analog_in_en[2] = 1'b1;
         pin_func_pkg::des_alt1: analog_out_en[2] = 1'b1;
         default: ;
      endcase
      case (des[3])
         pin_func_pkg::des_dedic:
         begin
            pin_out[3] = led_n[3];
            pin_oe[3]  = 1'b1;
         end
         pin_func_pkg::des_alt0: analog_in_en[3] = 1'b1;
         pin_func_pkg::des_alt1: analog_out_en[3] = 1'b1;
         default: ;
      endcase
   end

endmodule : gp_pin_function_select

/* File: testbench/pin_func_properties.sv */
// Concurrent checks on the pin function select block's ports
module pin_func_chk #(
   parameter int unsigned IDLE_CYC  = 20,
   parameter int unsigned PULSE_CYC = 8
) (
   // Clock, reset and register bus
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic        avs_waitrequest,
   // Link events and activity
   input wire logic        usb_traffic,
   input wire logic        usb_resume,
   input wire logic        usb_bus_reset,
   input wire logic        serial_rx_act,
   // Pin side
   input wire logic [3:0]  pin_out,
   input wire logic [3:0]  pin_oe,
   input wire logic [3:1]  analog_in_en,
   input wire logic [3:2]  analog_out_en,
   input wire logic        edge_detect_en,
   input wire logic        usb_pullup_en
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Shadow of the working bytes, idle length and LED pulse left
   logic [4:0]  set_q [4];
   logic [4:0]  set_d [4];
   logic [31:0] idle_q, idle_d, led_q, led_d;
   logic [3:0]  gp, dir, lvl, res;

   always_comb
   begin
      set_d = set_q;
      if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[5:4] == 2'h0)
         set_d[avs_address[3:2]] = avs_writedata[4:0];
      // Saturates so a long idle never wraps back to awake
      idle_d = idle_q + ((idle_q > IDLE_CYC) ? 32'h0 : 32'h1);
      if (usb_traffic || usb_resume || usb_bus_reset)
         idle_d = 32'h0;
      led_d = (led_q == 32'h0) ? 32'h0 : led_q - 32'h1;
      if (serial_rx_act)
         led_d = PULSE_CYC;
      for (int i = 0; i < 4; i++)
      begin
         gp[i]  = set_q[i][2:0] == 3'h0;
         dir[i] = set_q[i][3];
         lvl[i] = set_q[i][4];
      end
      res = {set_q[3][2:0] > 3'h3, set_q[2][2:0] > 3'h3,
             set_q[1][2:0] > 3'h4, set_q[0][2:0] > 3'h2};
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         set_q  <= '{5'h12, 5'h13, 5'h11, 5'h11};
         idle_q <= 32'h0;
         led_q  <= 32'h0;
      end
      else
      begin
         set_q  <= set_d;
         idle_q <= idle_d;
         led_q  <= led_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   AST_WAIT_ONE: assert property (s_req |=> !avs_waitrequest)
      else $error("waitrequest held longer than one cycle");
   AST_PULLUP: assert property (usb_pullup_en)
      else $error("pull-up dropped");
   AST_GPIO_OUT: assert property (((~pin_oe | (pin_out ^ lvl)) & gp & ~dir) == 4'h0)
      else $error("digital output pin not driving its level");
   AST_GPIO_IN: assert property ((pin_oe & gp & dir) == 4'h0)
      else $error("digital input pin driven");
   AST_RESERVED: assert property ((pin_oe & res) == 4'h0)
      else $error("reserved code pin driven");
   AST_ALT_ENABLES: assert property (analog_in_en == {set_q[3][2:0] == 3'h2,
      set_q[2][2:0] == 3'h2, set_q[1][2:0] == 3'h2} && edge_detect_en == (set_q[1][2:0] == 3'h4)
      && analog_out_en == {set_q[3][2:0] == 3'h3, set_q[2][2:0] == 3'h3})
      else $error("alternate enables disagree with designations");
   AST_SUSPEND_PIN: assert property (set_q[0][2:0] == 3'h1 |->
      pin_oe[0] && pin_out[0] == (idle_q <= IDLE_CYC))
      else $error("suspend indicator wrong");
   AST_RX_LED: assert property (set_q[0][2:0] == 3'h2 |->
      pin_oe[0] && pin_out[0] == (led_q == 32'h0))
      else $error("receive LED pulse wrong");
endmodule : pin_func_chk

bind gp_pin_function_select pin_func_chk #(
   .IDLE_CYC  (IDLE_CYC),
   .PULSE_CYC (PULSE_CYC)
) u_chk (
   .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_waitrequest, .usb_traffic, .usb_resume, .usb_bus_reset, .serial_rx_act, .pin_out,
   .pin_oe, .analog_in_en, .analog_out_en, .edge_detect_en, .usb_pullup_en
);

/* File: testbench/usb_host_model.sv */
// Host stand-in that drives the block's USB event inputs
module usb_host_model (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // Commands from the bench
   input  wire logic hold_idle,
   input  wire logic wake_req,
   input  wire logic reset_req,
   // Bus events
   output logic      usb_traffic,
   output logic      usb_resume,
   output logic      usb_bus_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] gap_q;

   always_ff @(posedge clk_sys)
   begin
      gap_q         <= rst ? 3'h0 : gap_q + 3'h1;
      // Silence is the only way the host asks for suspend
      usb_traffic   <= !rst && !hold_idle && gap_q == 3'h7;
      usb_resume    <= wake_req;
      usb_bus_reset <= reset_req;
   end
endmodule : usb_host_model

/* File: testbench/gp_pin_function_select_tb_top.sv */
// Self-checking bench for the pin function select block
module gp_pin_function_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned IDLE  = 20;
   localparam int unsigned PULSE = 8;
   logic        clk_sys        = 1'b0;
   logic        rst            = 1'b1;
   logic [5:0]  avs_address    = 6'h0;
   logic        avs_read       = 1'b0;
   logic        avs_write      = 1'b0;
   logic [31:0] avs_writedata  = 32'h0;
   logic [3:0]  avs_byteenable = 4'h0;
   logic        serial_rx_act  = 1'b0;
   logic        serial_tx_act  = 1'b0;
   logic        twowire_act    = 1'b0;
   logic        clk_src        = 1'b1;
   logic        hold_idle      = 1'b0;
   logic        wake_req       = 1'b0;
   logic        reset_req      = 1'b0;
   logic [31:0] avs_readdata, rd;
   logic        avs_waitrequest, usb_traffic, usb_resume, usb_bus_reset;
   logic [3:0]  pin_out, pin_oe;
   logic [3:1]  analog_in_en;
   logic [3:2]  analog_out_en;
   logic        edge_detect_en, usb_pullup_en;
   int          fail_count = 0;
   int          compares   = 0;

   always #2 clk_sys = ~clk_sys;

   gp_pin_function_select #(.IDLE_CYC(IDLE), .PULSE_CYC(PULSE)) uut (
      .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .usb_traffic, .usb_resume, .usb_bus_reset,
      .serial_rx_act, .serial_tx_act, .twowire_act, .clk_out_src(clk_src),
      .pin_in(4'h5), .pin_out, .pin_oe, .analog_in_en, .analog_out_en, .edge_detect_en,
      .usb_pullup_en
   );

   usb_host_model host (
      .clk_sys, .rst, .hold_idle, .wake_req, .reset_req, .usb_traffic, .usb_resume,
      .usb_bus_reset
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Request held until waitrequest is sampled low at a rising edge, released there
   task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d,
                      input logic [3:0] be);
      @(posedge clk_sys);
      avs_address    <= a;
      avs_writedata  <= {24'h0, d};
      avs_byteenable <= be;
      avs_write      <= we;
      avs_read       <= !we;
      do
      begin
         @(posedge clk_sys);
      end
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      logic [7:0] exp [4];
      exp = '{8'h12, 8'h13, 8'h11, 8'h11};
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b0, 6'(i * 4), 8'h0, 4'hf);
         chk("reset setting", {24'h0, exp[i]}, rd);
      end
      @(negedge clk_sys);
      chk("pins after reset", 32'hfb, {24'h0, pin_oe, pin_out});
      $display("test reset done");
   endtask : test_reset

   task automatic test_led;
      @(posedge clk_sys);
      serial_rx_act <= 1'b1;
      serial_tx_act <= 1'b1;
      twowire_act   <= 1'b1;
      @(posedge clk_sys);
      serial_rx_act <= 1'b0;
      serial_tx_act <= 1'b0;
      twowire_act   <= 1'b0;
      @(negedge clk_sys);
      chk("led pulse", 32'h0, 32'(pin_out & 4'hb));
      repeat (PULSE - 1) @(negedge clk_sys);
      chk("led last", 32'h0, 32'(pin_out & 4'hb));
      @(negedge clk_sys);
      chk("led end", 32'hb, 32'(pin_out & 4'hb));
      $display("test led done");
   endtask : test_led

   task automatic test_regs;
      bus(1'b1, 6'h10, 8'h00, 4'hf);
      bus(1'b0, 6'h00, 8'h00, 4'hf);
      chk("stored copy write", 32'h12, rd);
      bus(1'b1, 6'h04, 8'h00, 4'he);
      bus(1'b0, 6'h04, 8'h00, 4'hf);
      chk("masked write", 32'h13, rd);
      bus(1'b0, 6'h30, 8'h00, 4'hf);
      chk("unmapped read", 32'h0, rd);
      bus(1'b0, 6'h2c, 8'h00, 4'hf);
      chk("pin input", 32'h5, rd);
      bus(1'b1, 6'h0c, 8'h00, 4'hf);
      @(negedge clk_sys);
      chk("gpio low out", 32'h2, 32'({pin_oe[3], pin_out[3]}));
      bus(1'b1, 6'h0c, 8'h18, 4'hf);
      @(negedge clk_sys);
      chk("gpio input", 32'h0, 32'(pin_oe[3]));
      $display("test regs done");
   endtask : test_regs

   task automatic test_codes;
      // Codes that make each pin drive; bit n stands for code n
      logic [7:0] drives [4];
      drives = '{8'h07, 8'h0b, 8'h03, 8'h03};
      for (int p = 0; p < 4; p++)
         for (int c = 0; c < 8; c++)
         begin
            bus(1'b1, 6'(p * 4), 8'(c + 16), 4'hf);
            bus(1'b0, 6'(p * 4), 8'h00, 4'hf);
            chk("designation", 32'(c + 16), rd);
            chk("pin drive", 32'(drives[p][c]), 32'(pin_oe[p]));
            if (p == 1 && c == 1)
               chk("clock out", 32'h1, 32'(pin_out[1]));
         end
      bus(1'b1, 6'h08, 8'h11, 4'hf);
      $display("test codes done");
   endtask : test_codes

   task automatic test_suspend;
      bus(1'b1, 6'h00, 8'h11, 4'hf);
      bus(1'b1, 6'h20, 8'h02, 4'hf);
      @(negedge clk_sys);
      chk("awake", 32'h5, 32'(pin_out & 4'h5));
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk_sys);
         hold_idle <= 1'b1;
         repeat (IDLE + 8) @(negedge clk_sys);
         chk("suspended", 32'h0, 32'(pin_out & 4'h5));
         chk("pull-up", 32'h1, 32'(usb_pullup_en));
         @(posedge clk_sys);
         wake_req  <= (k == 0);
         reset_req <= (k == 1);
         @(posedge clk_sys);
         wake_req  <= 1'b0;
         reset_req <= 1'b0;
         repeat (3) @(negedge clk_sys);
         chk("left suspend", (k == 0) ? 32'h5 : 32'h1, 32'(pin_out & 4'h5));
         @(posedge clk_sys);
         hold_idle <= 1'b0;
      end
      $display("test suspend done");
   endtask : test_suspend

   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      test_reset();
      test_led();
      test_regs();
      test_codes();
      test_suspend();
      print_verdict();
   end

   initial
   begin
      repeat (5000) @(posedge clk_sys);
      fail_count++;
      print_verdict();
   end
endmodule : gp_pin_function_select_tb_top
